// >>> rtl/mcc_pkg.sv
/*
  mcc_pkg: shared constants, carrier types and helpers for the metering
  calculation control word block.
  assumes: one 20 MHz core clock; 16-bit signed conversion samples.
*/
package mcc_pkg;

  localparam int CTRL_W = 16;
  localparam int SMP_W = 16;
  localparam int NRG_W = 32;

  // control word field positions
  localparam int BIT_I2_ENABLE = 0;
  localparam int BIT_I1_SENSOR = 1;
  localparam int BIT_LEVEL_BASIS = 2;
  localparam int BIT_NEG_LO = 3;
  localparam int BIT_NEG_HI = 4;
  localparam int BIT_DCREM_V = 5;
  localparam int BIT_DCREM_IA = 6;
  localparam int BIT_DCREM_IB = 7;
  localparam int BIT_SPIKE_EN = 8;
  localparam int BIT_CMRR_EN = 9;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
  // bits that exist on every variant, and on the enhanced one only
  localparam logic [CTRL_W-1:0] CTRL_MASK_BASE = 16'h00FF;
  localparam logic [CTRL_W-1:0] CTRL_MASK_ENH = 16'h03FF;

  localparam int CH_V = 0;
  localparam int CH_IA = 1;
  localparam int CH_IB = 2;
  localparam int N_CH = 3;

  // scaling of the common-mode compensation product
  localparam int CMRR_SHIFT = 15;

  localparam logic signed [SMP_W-1:0] SMP_MAX = 16'sh7FFF;
  localparam logic signed [SMP_W-1:0] SMP_MIN = -16'sh8000;
  localparam logic [NRG_W-1:0] NRG_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    MCC_NEG_DROP,
    MCC_NEG_ABS,
    MCC_NEG_SIGNED,
    MCC_NEG_RSVD
  } mcc_neg_mode_e;

  typedef struct packed {
    logic signed [SMP_W-1:0] ib;
    logic signed [SMP_W-1:0] ia;
    logic signed [SMP_W-1:0] v;
  } mcc_chan_s;

  function automatic logic signed [SMP_W-1:0] mcc_sat(input logic signed [SMP_W+1:0] x);
    if (x > SMP_MAX) begin
      return SMP_MAX;
    end else if (x < SMP_MIN) begin
      return SMP_MIN;
    end
    return x[SMP_W-1:0];
  endfunction : mcc_sat

endpackage : mcc_pkg

// >>> rtl/mcc_spike_filter.sv
/*
  mcc_spike_filter: voltage spike filter with one cycle of latency.
  assumes: samples arrive as one-cycle valid pulses in the core clock domain.
*/
`timescale 1ns/1ns
module mcc_spike_filter (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_valid,
  input wire logic i_enable,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_limit,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_sample,
  output logic o_valid,
  output logic signed [mcc_pkg::SMP_W-1:0] o_sample
);
  import mcc_pkg::*;

  logic signed [SMP_W-1:0] prev1_reg;
  logic signed [SMP_W-1:0] prev2_reg;
  logic signed [SMP_W+1:0] diff;
  logic [SMP_W+1:0] diff_abs;
  logic signed [SMP_W+1:0] extrap;
  logic signed [SMP_W-1:0] filt_next;

  always_comb begin
    diff = 18'(i_sample) - 18'(prev1_reg);
    diff_abs = diff[SMP_W+1] ? 18'(-diff) : 18'(diff);
    extrap = (18'(prev1_reg) <<< 1) - 18'(prev2_reg);
    filt_next = i_sample;
    // limit at or below the step replaces the sample
    if (i_enable && ($signed(diff_abs) >= 18'(i_limit))) begin
      filt_next = mcc_sat(extrap);
    end
  end

  // history keeps the substituted value so one spike cannot seed the next
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      prev1_reg <= '0;
      prev2_reg <= '0;
      o_sample <= '0;
    end else if (i_valid) begin
      prev1_reg <= filt_next;
      prev2_reg <= prev1_reg;
      o_sample <= filt_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_valid;
    end
  end

endmodule : mcc_spike_filter

// >>> rtl/mcc_cm_reject.sv
/*
  mcc_cm_reject: common-mode rejection on the second current channel,
  one cycle of latency, output held between samples.
  assumes: reference is the offset-corrected voltage sample of the same set.
*/
`timescale 1ns/1ns
module mcc_cm_reject (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_valid,
  input wire logic i_enable,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_comp,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_ref,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_sample,
  output logic signed [mcc_pkg::SMP_W-1:0] o_sample
);
  import mcc_pkg::*;

  logic signed [2*SMP_W-1:0] prod;
  logic signed [SMP_W+1:0] adj;
  logic signed [SMP_W-1:0] res_next;

  always_comb begin
    prod = 32'(i_ref) * 32'(i_comp);
    adj = 18'(i_sample) - 18'(prod >>> CMRR_SHIFT);
    res_next = i_sample;
    // zero or negative compensation leaves the channel untouched
    if (i_enable && (i_comp > 16'sh0000)) begin
      res_next = mcc_sat(adj);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_sample <= '0;
    end else if (i_valid) begin
      o_sample <= res_next;
    end
  end

endmodule : mcc_cm_reject

// >>> rtl/mcc_calc_control.sv
/*
  mcc_calc_control: calculation control word of the metering processor and
  the datapath pieces it steers (offset choice, spike filter, common-mode
  rejection, negative energy handling, level-reached flag).
  assumes: the control word is written from the mailbox side as a one-cycle
  write strobe in this clock domain; all sample, energy and parameter
  inputs come from logic on the same 20 MHz clock.
*/
// Functional notes
// - A zero second-channel enable keeps that channel out of use, a one opens it for a tamper sensor.
// - Sensor select at zero measures line current on the first channel and one is reserved for software.
// - With level basis zero the flag sets when the energy sum reaches the threshold, which is then subtracted.
// - With level basis one the flag sets after threshold measurements and the counter restarts from zero.
// - The negative energy code drops, takes absolute or sums signed negative energy and sets the flag.
// - DC removal enables for voltage, first and second current sit at bits five, six and seven.
// - On the original variant a channel with DC removal off uses its startup offset.
// - A channel with DC removal on uses the running DC removal estimate.
// - On the enhanced variant a channel with DC removal off uses an offset of zero.
// - Original variant with first-channel removal on and a coil sensor also clears DC in the integrator.
// - Bit eight enables the voltage spike filter, on the enhanced variant only.
// - Bit nine enables second-channel common-mode rejection, on the enhanced variant only.
// - The spike filter replaces a sample whose step reaches the limit with a two-point extrapolation.
// - Common-mode rejection acts only while the compensation parameter is above zero.
`timescale 1ns/1ns
module mcc_calc_control #(
  parameter bit ENHANCED = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ctrl_wr,
  input wire logic [mcc_pkg::CTRL_W-1:0] i_ctrl_wdata,
  output logic [mcc_pkg::CTRL_W-1:0] o_ctrl_rdata,
  input wire logic i_sample_valid,
  input wire mcc_pkg::mcc_chan_s i_sample,
  input wire mcc_pkg::mcc_chan_s i_init_offset,
  input wire mcc_pkg::mcc_chan_s i_dc_offset,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_spike_limit_param,
  input wire logic signed [mcc_pkg::SMP_W-1:0] i_common_mode_comp_param,
  input wire logic i_energy_valid,
  input wire logic signed [mcc_pkg::NRG_W-1:0] i_energy,
  input wire logic i_meas_done,
  input wire logic [mcc_pkg::NRG_W-1:0] i_level_threshold_param,
  input wire logic i_level_flag_clr,
  input wire logic i_neg_flag_clr,
  output logic o_corr_valid,
  output mcc_pkg::mcc_chan_s o_corr,
  output logic o_level_reached_flag,
  output logic o_negative_energy_flag,
  output logic signed [mcc_pkg::NRG_W-1:0] o_energy_sum,
  output logic signed [mcc_pkg::NRG_W-1:0] o_active_energy,
  output logic [mcc_pkg::NRG_W-1:0] o_meas_count,
  output logic o_power_factor_negative,
  output logic o_second_current_channel_enable,
  output logic o_coil_integrator_dc_removal
);
  import mcc_pkg::*;

  localparam logic [CTRL_W-1:0] CTRL_MASK = ENHANCED ? CTRL_MASK_ENH : CTRL_MASK_BASE;

  logic [CTRL_W-1:0] calc_control_0_reg;
  logic second_current_channel_enable;
  logic first_current_sensor_select;
  logic level_flag_basis;
  mcc_neg_mode_e neg_mode;
  logic [N_CH-1:0] dc_removal_en;
  logic voltage_spike_filter_enable;
  logic current_b_common_mode_enable;

  logic signed [SMP_W-1:0] raw [N_CH];
  logic signed [SMP_W-1:0] init_off [N_CH];
  logic signed [SMP_W-1:0] dc_off [N_CH];
  logic signed [SMP_W-1:0] corr_next [N_CH];
  logic signed [SMP_W-1:0] corr_reg [N_CH];
  logic corr_valid_reg;
  logic signed [SMP_W-1:0] ia_delay_reg;
  logic spike_valid;
  logic signed [SMP_W-1:0] spike_out;
  logic signed [SMP_W-1:0] cmrr_out;

  logic signed [NRG_W-1:0] add_next;
  logic signed [NRG_W-1:0] active_next;
  logic neg_set;
  logic pf_neg_next;
  logic signed [NRG_W:0] sum_wide;
  logic level_hit_energy;
  logic level_hit_count;
  logic level_set;
  logic [NRG_W-1:0] count_inc;

  // control word; reserved and absent bits never stored
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      calc_control_0_reg <= CTRL_RESET;
    end else if (i_ctrl_wr) begin
      calc_control_0_reg <= i_ctrl_wdata & CTRL_MASK;
    end
  end

  always_comb begin
    second_current_channel_enable = calc_control_0_reg[BIT_I2_ENABLE];
    first_current_sensor_select = calc_control_0_reg[BIT_I1_SENSOR];
    level_flag_basis = calc_control_0_reg[BIT_LEVEL_BASIS];
    neg_mode = mcc_neg_mode_e'({calc_control_0_reg[BIT_NEG_HI], calc_control_0_reg[BIT_NEG_LO]});
    dc_removal_en[CH_V] = calc_control_0_reg[BIT_DCREM_V];
    dc_removal_en[CH_IA] = calc_control_0_reg[BIT_DCREM_IA];
    dc_removal_en[CH_IB] = calc_control_0_reg[BIT_DCREM_IB];
    voltage_spike_filter_enable = ENHANCED && calc_control_0_reg[BIT_SPIKE_EN];
    current_b_common_mode_enable = ENHANCED && calc_control_0_reg[BIT_CMRR_EN];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_ctrl_rdata <= CTRL_RESET;
    end else begin
      o_ctrl_rdata <= i_ctrl_wr ? (i_ctrl_wdata & CTRL_MASK) : calc_control_0_reg;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_second_current_channel_enable <= 1'b0;
      o_coil_integrator_dc_removal <= 1'b0;
    end else begin
      o_second_current_channel_enable <= second_current_channel_enable;
      // reserved select value is taken as the coil sensor
      o_coil_integrator_dc_removal <= !ENHANCED && dc_removal_en[CH_IA]
        && first_current_sensor_select;
    end
  end

  always_comb begin
    raw[CH_V] = i_sample.v;
    raw[CH_IA] = i_sample.ia;
    raw[CH_IB] = i_sample.ib;
    init_off[CH_V] = i_init_offset.v;
    init_off[CH_IA] = i_init_offset.ia;
    init_off[CH_IB] = i_init_offset.ib;
    dc_off[CH_V] = i_dc_offset.v;
    dc_off[CH_IA] = i_dc_offset.ia;
    dc_off[CH_IB] = i_dc_offset.ib;
  end

  // per-channel offset choice
  for (genvar ch = 0; ch < N_CH; ch++) begin : g_offset
    logic signed [SMP_W-1:0] off_sel;
    always_comb begin
      off_sel = '0;
      if (dc_removal_en[ch]) begin
        off_sel = dc_off[ch];
      end else if (!ENHANCED) begin
        off_sel = init_off[ch];
      end else begin
        off_sel = '0;
      end
      corr_next[ch] = mcc_sat(18'(raw[ch]) - 18'(off_sel));
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_reset_n) begin
        corr_reg[ch] <= '0;
      end else if (i_sample_valid) begin
        corr_reg[ch] <= corr_next[ch];
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      corr_valid_reg <= 1'b0;
    end else begin
      corr_valid_reg <= i_sample_valid;
    end
  end

  // second stage: filter, rejection, matching delay for the first current
  mcc_spike_filter u_spike (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_valid(corr_valid_reg),
    .i_enable(voltage_spike_filter_enable),
    .i_limit(i_spike_limit_param),
    .i_sample(corr_reg[CH_V]),
    .o_valid(spike_valid),
    .o_sample(spike_out)
  );

  mcc_cm_reject u_cmrr (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_valid(corr_valid_reg),
    .i_enable(current_b_common_mode_enable),
    .i_comp(i_common_mode_comp_param),
    .i_ref(corr_reg[CH_V]),
    .i_sample(second_current_channel_enable ? corr_reg[CH_IB] : '0),
    .o_sample(cmrr_out)
  );

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ia_delay_reg <= '0;
    end else if (corr_valid_reg) begin
      ia_delay_reg <= corr_reg[CH_IA];
    end
  end

  assign o_corr_valid = spike_valid;
  assign o_corr = '{ib: cmrr_out, ia: ia_delay_reg, v: spike_out};

  // negative energy handling
  always_comb begin
    add_next = i_energy;
    active_next = i_energy;
    neg_set = 1'b0;
    pf_neg_next = 1'b0;
    if (i_energy < 32'sh0000_0000) begin
      case (neg_mode)
        MCC_NEG_DROP: begin
          add_next = '0;
          active_next = '0;
          neg_set = 1'b1;
        end
        MCC_NEG_ABS: begin
          add_next = -i_energy;
          active_next = -i_energy;
          neg_set = 1'b1;
        end
        MCC_NEG_SIGNED: begin
          pf_neg_next = 1'b1;
          neg_set = 1'b1;
        end
        default: begin
          // reserved code: behaves as drop but raises nothing
          add_next = '0;
          active_next = '0;
        end
      endcase
    end
  end

  // level detection on energy or on measurement count
  always_comb begin
    sum_wide = 33'(o_energy_sum) + 33'(add_next);
    level_hit_energy = i_energy_valid && !level_flag_basis
      && (sum_wide >= $signed({1'b0, i_level_threshold_param}));
    count_inc = o_meas_count + 32'h0000_0001;
    level_hit_count = i_meas_done && level_flag_basis
      && (count_inc >= i_level_threshold_param);
    level_set = level_hit_energy || level_hit_count;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_energy_sum <= '0;
    end else if (i_energy_valid && !level_flag_basis) begin
      if (level_hit_energy) begin
        o_energy_sum <= NRG_W'(sum_wide - $signed({1'b0, i_level_threshold_param}));
      end else begin
        o_energy_sum <= NRG_W'(sum_wide);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_meas_count <= NRG_ZERO;
    end else if (i_meas_done && level_flag_basis) begin
      o_meas_count <= level_hit_count ? NRG_ZERO : count_inc;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_active_energy <= '0;
      o_power_factor_negative <= 1'b0;
    end else if (i_energy_valid) begin
      o_active_energy <= active_next;
      o_power_factor_negative <= pf_neg_next;
    end
  end

  // a set in the clearing cycle wins so no event is lost
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_level_reached_flag <= 1'b0;
    end else if (level_set) begin
      o_level_reached_flag <= 1'b1;
    end else if (i_level_flag_clr) begin
      o_level_reached_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_negative_energy_flag <= 1'b0;
    end else if (i_energy_valid && neg_set) begin
      o_negative_energy_flag <= 1'b1;
    end else if (i_neg_flag_clr) begin
      o_negative_energy_flag <= 1'b0;
    end
  end

endmodule : mcc_calc_control

// >>> verification/mcc_calc_control_assertions.sv
/*
  mcc_calc_control_assertions: timing checks on the control word, sample
  pipeline, energy sum, measurement count and flags.
  assumes: bound to every mcc_calc_control instance; one clock, sync active-low reset.
*/
`timescale 1ns/1ns
module mcc_calc_control_assertions #(
  parameter bit ENHANCED = 1'b1
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_ctrl_wr,
  input wire logic [mcc_pkg::CTRL_W-1:0] i_ctrl_wdata,
  input wire logic [mcc_pkg::CTRL_W-1:0] o_ctrl_rdata,
  input wire logic i_sample_valid,
  input wire logic i_energy_valid,
  input wire logic signed [mcc_pkg::NRG_W-1:0] i_energy,
  input wire logic i_meas_done,
  input wire logic [mcc_pkg::NRG_W-1:0] i_level_threshold_param,
  input wire logic o_corr_valid,
  input wire logic o_level_reached_flag,
  input wire logic o_negative_energy_flag,
  input wire logic signed [mcc_pkg::NRG_W-1:0] o_energy_sum,
  input wire logic signed [mcc_pkg::NRG_W-1:0] o_active_energy,
  input wire logic [mcc_pkg::NRG_W-1:0] o_meas_count,
  input wire logic o_power_factor_negative,
  input wire logic o_second_current_channel_enable,
  input wire logic o_coil_integrator_dc_removal
);
  import mcc_pkg::*;
  localparam logic [CTRL_W-1:0] MASK = ENHANCED ? CTRL_MASK_ENH : CTRL_MASK_BASE;
  logic signed [33:0] thr_s;
  logic signed [33:0] sum_inc;
  logic [31:0] sum_wrap;
  logic [32:0] cnt_inc;
  logic nrg_take;
  logic cnt_take;
  // wide sums so a threshold near the top cannot wrap the compare
  assign thr_s = $signed({2'b00, i_level_threshold_param});
  assign sum_inc = 34'(o_energy_sum) + 34'(i_energy);
  assign sum_wrap = 32'(sum_inc - thr_s);
  assign cnt_inc = {1'b0, o_meas_count} + 33'h0_0000_0001;
  assign nrg_take = i_energy_valid && !o_ctrl_rdata[BIT_LEVEL_BASIS];
  assign cnt_take = i_meas_done && o_ctrl_rdata[BIT_LEVEL_BASIS];
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_out_two; ##2 o_corr_valid; endsequence
  sequence s_count_wrap; o_level_reached_flag && o_meas_count == 32'h0000_0000; endsequence
  property p_rsvd; o_ctrl_rdata[15:10] == 6'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");
  property p_write; i_ctrl_wr |=> o_ctrl_rdata == ($past(i_ctrl_wdata) & MASK); endproperty
  a_write: assert property (p_write) else $error("control word write wrong");
  property p_hold; !i_ctrl_wr |=> $stable(o_ctrl_rdata); endproperty
  a_hold: assert property (p_hold) else $error("control word changed unwritten");
  property p_i2; 1'b1 |=> o_second_current_channel_enable == $past(o_ctrl_rdata[BIT_I2_ENABLE]); endproperty
  a_i2: assert property (p_i2) else $error("second channel enable wrong");
  property p_coil;
    1'b1 |=> o_coil_integrator_dc_removal == (!ENHANCED && $past(o_ctrl_rdata[6]) && $past(o_ctrl_rdata[1]));
  endproperty
  a_coil: assert property (p_coil) else $error("integrator dc removal wrong");
  property p_corr; i_sample_valid |-> s_out_two; endproperty
  a_corr: assert property (p_corr) else $error("corrected sample late");
  property p_lvl_nrg;
    nrg_take && !i_energy[31] && sum_inc >= thr_s |=> o_level_reached_flag && o_energy_sum == $past(sum_wrap);
  endproperty
  a_lvl_nrg: assert property (p_lvl_nrg) else $error("energy level wrap wrong");
  property p_sum_frozen; !nrg_take |=> $stable(o_energy_sum); endproperty
  a_sum_frozen: assert property (p_sum_frozen) else $error("energy sum moved");
  property p_neg; nrg_take && i_energy[31] && o_ctrl_rdata[4:3] != 2'h3 |=> o_negative_energy_flag; endproperty
  a_neg: assert property (p_neg) else $error("negative energy flag missing");
  property p_pf; nrg_take && i_energy[31] && o_ctrl_rdata[4:3] == 2'h2 |=> o_power_factor_negative; endproperty
  a_pf: assert property (p_pf) else $error("power factor sign missing");
  property p_drop; nrg_take && i_energy[31] && o_ctrl_rdata[4:3] == 2'h0 |=> o_active_energy == 32'h0000_0000;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped energy not zero");
  property p_cnt_wrap; cnt_take && cnt_inc >= {1'b0, i_level_threshold_param} |=> s_count_wrap; endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("count wrap wrong");
  property p_cnt_inc;
    cnt_take && cnt_inc < {1'b0, i_level_threshold_param} |=> o_meas_count == $past(o_meas_count) + 32'h0000_0001;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count step wrong");
  property p_cnt_frozen; !cnt_take |=> $stable(o_meas_count); endproperty
  a_cnt_frozen: assert property (p_cnt_frozen) else $error("count moved");
endmodule : mcc_calc_control_assertions

bind mcc_calc_control mcc_calc_control_assertions #(.ENHANCED(ENHANCED)) i_mcc_calc_control_assertions (
  .i_core_clk, .i_reset_n, .i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_rdata, .i_sample_valid, .i_energy_valid,
  .i_energy, .i_meas_done, .i_level_threshold_param, .o_corr_valid, .o_level_reached_flag,
  .o_negative_energy_flag, .o_energy_sum, .o_active_energy, .o_meas_count, .o_power_factor_negative,
  .o_second_current_channel_enable, .o_coil_integrator_dc_removal);

// >>> verification/mcc_calc_control_tb_top.sv
/*
  mcc_calc_control_tb_top: self-checking bench, both variants on shared stimulus.
  assumes: 20 MHz core clock; bench drives inputs on the falling edge.
*/
`timescale 1ns/1ns
module mcc_calc_control_tb_top;
  import mcc_pkg::*;
  logic i_core_clk, i_reset_n, i_ctrl_wr, i_sample_valid, i_energy_valid, i_meas_done, i_level_flag_clr;
  logic i_neg_flag_clr, o_corr_valid, o_level_reached_flag, o_negative_energy_flag, o_power_factor_negative;
  logic o_second_current_channel_enable, o_coil_integrator_dc_removal, coil_orig;
  logic [CTRL_W-1:0] i_ctrl_wdata, o_ctrl_rdata, rdata_orig;
  mcc_chan_s i_sample, i_init_offset, i_dc_offset, o_corr, corr_orig;
  logic signed [SMP_W-1:0] i_spike_limit_param, i_common_mode_comp_param;
  logic signed [NRG_W-1:0] i_energy, o_energy_sum, o_active_energy;
  logic [NRG_W-1:0] i_level_threshold_param, o_meas_count;
  int failures = 0;
  int checks = 0;

  mcc_calc_control #(.ENHANCED(1'b1)) i_mcc_calc_control (
    .i_core_clk, .i_reset_n, .i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_rdata, .i_sample_valid, .i_sample, .i_init_offset,
    .i_dc_offset, .i_spike_limit_param, .i_common_mode_comp_param, .i_energy_valid, .i_energy, .i_meas_done,
    .i_level_threshold_param, .i_level_flag_clr, .i_neg_flag_clr, .o_corr_valid, .o_corr, .o_level_reached_flag,
    .o_negative_energy_flag, .o_energy_sum, .o_active_energy, .o_meas_count, .o_power_factor_negative,
    .o_second_current_channel_enable, .o_coil_integrator_dc_removal);
  // original variant sees the same stimulus so the mask, coil, spike, offset and rejection checks can contrast the two
  mcc_calc_control #(.ENHANCED(1'b0)) i_mcc_calc_control_orig (
    .i_core_clk, .i_reset_n, .i_ctrl_wr, .i_ctrl_wdata, .o_ctrl_rdata(rdata_orig), .i_sample_valid, .i_sample,
    .i_init_offset, .i_dc_offset, .i_spike_limit_param, .i_common_mode_comp_param, .i_energy_valid, .i_energy,
    .i_meas_done, .i_level_threshold_param, .i_level_flag_clr, .i_neg_flag_clr, .o_corr_valid(), .o_corr(corr_orig),
    .o_level_reached_flag(), .o_negative_energy_flag(), .o_energy_sum(), .o_active_energy(), .o_meas_count(),
    .o_power_factor_negative(), .o_second_current_channel_enable(), .o_coil_integrator_dc_removal(coil_orig));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : chk

  task automatic wr_ctrl(input logic [15:0] d);
    @(negedge i_core_clk);
    i_ctrl_wr = 1'b1;
    i_ctrl_wdata = d;
    @(negedge i_core_clk);
    i_ctrl_wr = 1'b0;
  endtask : wr_ctrl

  // two-cycle latency and a one-cycle valid, so the result is read two falling edges after the strobe
  task automatic samp(input mcc_chan_s s);
    @(negedge i_core_clk);
    i_sample_valid = 1'b1;
    i_sample = s;
    @(negedge i_core_clk);
    i_sample_valid = 1'b0;
    @(negedge i_core_clk);
    chk(o_corr_valid, 1'b1, "corrected sample valid");
  endtask : samp

  task automatic nrg(input logic [31:0] e);
    @(negedge i_core_clk);
    i_energy_valid = 1'b1;
    i_energy = e;
    @(negedge i_core_clk);
    i_energy_valid = 1'b0;
  endtask : nrg

  task automatic meas;
    @(negedge i_core_clk);
    i_meas_done = 1'b1;
    @(negedge i_core_clk);
    i_meas_done = 1'b0;
  endtask : meas

  task automatic clr;
    @(negedge i_core_clk);
    {i_level_flag_clr, i_neg_flag_clr} = 2'h3;
    @(negedge i_core_clk);
    {i_level_flag_clr, i_neg_flag_clr} = 2'h0;
  endtask : clr

  task automatic t_ctrl;
    chk(o_ctrl_rdata, 16'h0000, "control reset value");
    wr_ctrl(16'hFFFF);
    chk(o_ctrl_rdata, 16'h03FF, "enhanced control mask");
    chk(rdata_orig, 16'h00FF, "original control mask");
    wr_ctrl(16'h0042);
    @(negedge i_core_clk);
    chk(coil_orig, 1'b1, "integrator dc removal on");
    chk(o_coil_integrator_dc_removal, 1'b0, "integrator dc removal enhanced");
    chk(o_second_current_channel_enable, 1'b0, "second channel off");
    wr_ctrl(16'h0001);
    @(negedge i_core_clk);
    chk(o_second_current_channel_enable, 1'b1, "second channel on");
    $display("test control word done");
  endtask : t_ctrl

  // step of exactly the limit must be replaced as well
  task automatic t_spike;
    logic [15:0] vin [4] = '{16'h000A, 16'h0014, 16'h00C8, 16'h0050};
    logic [15:0] vexp [4] = '{16'h000A, 16'h0014, 16'h001E, 16'h0028};
    wr_ctrl(16'h0100);
    i_spike_limit_param = 16'h0032;
    for (int i = 0; i < 4; i++) begin
      samp('{ib: 16'h0000, ia: 16'h0000, v: vin[i]});
      chk($unsigned(o_corr.v), vexp[i], "spike filter output");
    end
    chk($unsigned(corr_orig.v), 16'h0050, "original has no filter");
    $display("test spike filter done");
  endtask : t_spike

  task automatic t_offset;
    i_init_offset = 48'h001E_0014_000A;
    i_dc_offset = 48'h0003_0002_0001;
    wr_ctrl(16'h0021);
    samp(48'h012C_00C8_0064);
    chk(o_corr, 48'h012C_00C8_0063, "enhanced voltage removal");
    chk(corr_orig, 48'h010E_00B4_0063, "original voltage removal");
    wr_ctrl(16'h00C1);
    samp(48'h012C_00C8_0064);
    chk(o_corr, 48'h0129_00C6_0064, "enhanced current removal");
    chk(corr_orig, 48'h0129_00C6_005A, "original current removal");
    $display("test offsets done");
  endtask : t_offset

  task automatic t_cmrr;
    logic [15:0] comp [3] = '{16'h4000, 16'h0000, 16'hFFFF};
    logic [15:0] ibexp [3] = '{16'h09C4, 16'h0BB8, 16'h0BB8};
    wr_ctrl(16'h0201);
    for (int i = 0; i < 3; i++) begin
      i_common_mode_comp_param = comp[i];
      samp(48'h0BB8_0000_03E8);
      chk($unsigned(o_corr.ib), ibexp[i], "common mode rejection");
      chk($unsigned(corr_orig.ib), 16'h0B9A, "original has no rejection");
    end
    $display("test common mode done");
  endtask : t_cmrr

  task automatic t_energy;
    i_level_threshold_param = 32'h0000_0064;
    wr_ctrl(16'h0008);
    nrg(32'hFFFF_FFC4);
    chk($unsigned(o_energy_sum), 32'h0000_003C, "absolute energy summed");
    chk(o_negative_energy_flag, 1'b1, "negative flag absolute");
    nrg(32'h0000_0028);
    chk(o_level_reached_flag, 1'b1, "energy level reached");
    chk($unsigned(o_energy_sum), 32'h0000_0000, "threshold subtracted");
    clr;
    chk(o_level_reached_flag, 1'b0, "level flag cleared");
    wr_ctrl(16'h0010);
    nrg(32'hFFFF_FFE2);
    chk($unsigned(o_energy_sum), 32'hFFFF_FFE2, "signed energy summed");
    chk(o_power_factor_negative, 1'b1, "power factor negative");
    clr;
    wr_ctrl(16'h0000);
    nrg(32'hFFFF_FFFB);
    chk($unsigned(o_active_energy), 32'h0000_0000, "active energy dropped");
    chk($unsigned(o_energy_sum), 32'hFFFF_FFE2, "dropped energy not summed");
    chk(o_negative_energy_flag, 1'b1, "negative flag dropped");
    clr;
    wr_ctrl(16'h0018);
    nrg(32'hFFFF_FFFB);
    chk(o_negative_energy_flag, 1'b0, "reserved mode no flag");
    $display("test energy done");
  endtask : t_energy

  task automatic t_count;
    clr;
    i_level_threshold_param = 32'h0000_0003;
    wr_ctrl(16'h0004);
    nrg(32'h0000_0032);
    chk($unsigned(o_energy_sum), 32'hFFFF_FFE2, "sum frozen in count mode");
    for (int i = 1; i <= 3; i++) begin
      meas;
      chk(o_meas_count, (i == 3) ? 48'h0 : 48'(i), "measurement count");
      chk(o_level_reached_flag, i == 3, "count level flag");
    end
    $display("test count done");
  endtask : t_count

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  initial begin
    {i_reset_n, i_ctrl_wr, i_sample_valid, i_energy_valid, i_meas_done, i_level_flag_clr, i_neg_flag_clr} = 7'h00;
    i_ctrl_wdata = 16'h0000;
    {i_sample, i_init_offset, i_dc_offset} = 144'h0;
    {i_spike_limit_param, i_common_mode_comp_param} = 32'h0000_0000;
    {i_energy, i_level_threshold_param} = 64'h0;
    repeat (2) @(negedge i_core_clk);
    i_reset_n = 1'b1;
    t_ctrl;
    t_spike;
    t_offset;
    t_cmrr;
    t_energy;
    t_count;
    test_done;
  end

  // whole run is under a hundred cycles; this only cuts a hang short
  initial begin
    repeat (3000) @(posedge i_core_clk);
    failures++;
    test_done;
  end
endmodule : mcc_calc_control_tb_top
